// ===== design/asfm_ctrl.sv
// Purpose: Frame and mode control of a 12-bit serial-output converter
// Assumes: sclk and select_n are synchronous to core_clk; one pulse per sclk edge
// Notes:   Result word is supplied by the conversion core on sample_result
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Result is unsigned straight binary code
// - Select fall enters normal, starts conversion
// - Shutdown holds until select falls again
// - Rise between tenth and sixteenth aborts, normal
// - Output released after sixteen clocks
// - Rise between second and tenth: shutdown
// - Rise before second fall keeps mode
// - Wake conversion result flagged unusable
// - Early rise after wake returns shutdown
// - Four zeros, twelve bits, MSB first
// - Sample at select fall, track at 13th rise
// - Release at 16th fall or select rise
// - Wake delay is one microsecond
module asfm_ctrl #(
    parameter int RESULT_BITS = asfm_pkg::RESULT_BITS
) (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   sclk,
    input  wire logic                   select_n,
    input  wire logic [RESULT_BITS-1:0] sample_result,
    output logic                        serial_result_out,
    output logic                        serial_result_oe,
    output logic                        hold_active,
    output logic                        sample_strobe,
    output logic                        shutdown_mode,
    output logic                        result_unusable,
    output logic                        wake_done
);
    // ==========================================================
    // Edge detection
    // Edges come from the previous sample, so each sclk level
    // must last one core_clk cycle at least
    logic sclk_q;
    logic sclk_d;
    logic sel_q;
    logic sel_d;
    logic sclk_fall;
    logic sclk_rise;
    logic sel_fall;
    logic sel_rise;
    assign sclk_fall = sclk_q & ~sclk;
    assign sclk_rise = ~sclk_q & sclk;
    assign sel_fall  = sel_q & ~select_n;
    assign sel_rise  = ~sel_q & select_n;

    // ==========================================================
    // Frame state
    asfm_pkg::asfm_state_type state_q;
    asfm_pkg::asfm_state_type state_d;
    logic [4:0]               falls_q;
    logic [4:0]               falls_d;
    logic [4:0]               rises_q;
    logic [4:0]               rises_d;
    logic [15:0]              shift_q;
    logic [15:0]              shift_d;
    logic                     sdo_q;
    logic                     sdo_d;
    logic                     oe_q;
    logic                     oe_d;
    logic                     hold_q;
    logic                     hold_d;
    logic                     samp_q;
    logic                     samp_d;
    logic                     shut_q;
    logic                     shut_d;
    logic                     waking_q;
    logic                     waking_d;
    logic                     unus_q;
    logic                     unus_d;
    logic [5:0]               wake_cnt_q;
    logic [5:0]               wake_cnt_d;
    logic                     wdone_q;
    logic                     wdone_d;

    // ==========================================================
    // Helpers
    // Saturates so a long idle-low frame cannot wrap the count
    function automatic logic [4:0] inc_sat(input logic [4:0] v);
        inc_sat = (v == asfm_pkg::CNT_MAX) ? v : v + 5'h01;
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        sclk_d     = sclk;
        sel_d      = select_n;
        state_d    = state_q;
        falls_d    = falls_q;
        rises_d    = rises_q;
        shift_d    = shift_q;
        sdo_d      = sdo_q;
        oe_d       = oe_q;
        hold_d     = hold_q;
        samp_d     = 1'b0;
        shut_d     = shut_q;
        waking_d   = waking_q;
        unus_d     = unus_q;
        wake_cnt_d = wake_cnt_q;
        wdone_d    = wdone_q;
        // Wake delay runs from select fall out of shutdown
        // Counter stops at its limit, so done stays set until the next wake
        if (waking_q && wake_cnt_q != 6'(asfm_pkg::WAKE_CYCLES)) begin
            wake_cnt_d = wake_cnt_q + 6'h01;
        end else if (waking_q) begin
            wdone_d = 1'b1;
        end
        if (sel_fall) begin
            state_d = asfm_pkg::ST_FRAME;
            falls_d = asfm_pkg::CNT_ZERO;
            rises_d = asfm_pkg::CNT_ZERO;
            // Straight binary word, zeros lead, MSB first
            shift_d = {{asfm_pkg::LEAD_ZEROS{1'b0}}, sample_result, 1'b0};
            sdo_d   = 1'b0;
            oe_d    = 1'b1;
            hold_d  = 1'b1;
            samp_d  = 1'b1;
            unus_d  = shut_q;
            // A fall from shutdown restarts the wake delay
            if (shut_q) begin
                waking_d   = 1'b1;
                wake_cnt_d = 6'h00;
                wdone_d    = 1'b0;
            end
            shut_d = 1'b0;
        end else if (state_q == asfm_pkg::ST_FRAME && sel_rise) begin
            state_d = asfm_pkg::ST_IDLE;
            oe_d    = 1'b0;
            hold_d  = 1'b0;
            // Count of falls decides the mode
            // Wake frame comes first: an early rise goes back to shutdown
            if (unus_q && falls_q < 5'(asfm_pkg::NORMAL_EDGES)) begin
                shut_d = 1'b1;
            end else if (falls_q < 5'(asfm_pkg::GLITCH_EDGES)) begin
                shut_d = shut_q;
            end else if (falls_q < 5'(asfm_pkg::NORMAL_EDGES)) begin
                shut_d = 1'b1;
            end else begin
                shut_d = 1'b0;
            end
        end else if (state_q == asfm_pkg::ST_FRAME) begin
            if (sclk_rise) begin
                rises_d = inc_sat(rises_q);
                if (rises_d == 5'(asfm_pkg::TRACK_RISE)) begin
                    hold_d = 1'b0;
                end
            end
            if (sclk_fall) begin
                falls_d = inc_sat(falls_q);
                sdo_d   = shift_q[15];
                shift_d = {shift_q[14:0], 1'b0};
                if (falls_d == 5'(asfm_pkg::WORD_EDGES)) begin
                    oe_d    = 1'b0;
                    state_d = asfm_pkg::ST_DONE;
                end
            end
        end else if (state_q == asfm_pkg::ST_DONE && sel_rise) begin
            // Full word already out, the rise only closes the frame
            state_d = asfm_pkg::ST_IDLE;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclk_q     <= 1'b0;
            sel_q      <= 1'b1;
            state_q    <= asfm_pkg::ST_IDLE;
            falls_q    <= asfm_pkg::CNT_ZERO;
            rises_q    <= asfm_pkg::CNT_ZERO;
            shift_q    <= 16'h0000;
            sdo_q      <= 1'b0;
            oe_q       <= 1'b0;
            hold_q     <= 1'b0;
            samp_q     <= 1'b0;
            shut_q     <= 1'b0;
            waking_q   <= 1'b0;
            unus_q     <= 1'b1;
            wake_cnt_q <= 6'h00;
            wdone_q    <= 1'b0;
        end else begin
            sclk_q     <= sclk_d;
            sel_q      <= sel_d;
            state_q    <= state_d;
            falls_q    <= falls_d;
            rises_q    <= rises_d;
            shift_q    <= shift_d;
            sdo_q      <= sdo_d;
            oe_q       <= oe_d;
            hold_q     <= hold_d;
            samp_q     <= samp_d;
            shut_q     <= shut_d;
            waking_q   <= waking_d;
            unus_q     <= unus_d;
            wake_cnt_q <= wake_cnt_d;
            wdone_q    <= wdone_d;
        end
    end

    // ==========================================================
    // Outputs
    // Straight from flip-flops, no logic after the registers
    assign serial_result_out = sdo_q;
    assign serial_result_oe  = oe_q;
    assign hold_active       = hold_q;
    assign sample_strobe     = samp_q;
    assign shutdown_mode     = shut_q;
    assign result_unusable   = unus_q;
    assign wake_done         = wdone_q;
endmodule
`default_nettype wire

// ===== design/asfm_pkg.sv
// Purpose: Shared constants for the serial converter frame and mode control
// Assumes: Serial clock and frame select are sampled in the core_clk domain
// Notes:   Edge numbers count serial clock falling edges after select falls
package asfm_pkg;
    localparam int RESULT_BITS     = 12;
    localparam int CODE_STEPS      = 4096;
    localparam int LEAD_ZEROS      = 3;
    localparam int WORD_EDGES      = 16;
    localparam int FRAME_MIN_EDGES = 20;
    localparam int GLITCH_EDGES    = 2;
    localparam int NORMAL_EDGES    = 10;
    localparam int TRACK_RISE      = 13;
    localparam int ACQ_NS          = 350;
    localparam int WAKE_NS         = 1000;
    localparam int CLK_MHZ         = 25;
    localparam int CLK_PERIOD_NS   = 40;
    // Least times round up
    localparam int ACQ_CYCLES  = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] CNT_ZERO = 5'h00;
    localparam logic [4:0] CNT_MAX  = 5'h1F;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FRAME = 3'b010,
        ST_DONE  = 3'b100
    } asfm_state_type;
endpackage

// ===== tb/asfm_ctrl_sva.sv
// Purpose: Port checks of frame and mode control
// Assumes: Serial clock falls counted per frame
// Notes:   Count saturates like the design
`timescale 1ns/1ns
`default_nettype none
module asfm_ctrl_sva (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic serial_result_out,
    input wire logic serial_result_oe,
    input wire logic hold_active,
    input wire logic sample_strobe,
    input wire logic shutdown_mode,
    input wire logic result_unusable
);
    logic       sclk_q;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (select_n)
            cnt_d = 5'h00;
        else if (sclk_q && !sclk && cnt_q != 5'h1F)
            cnt_d = cnt_q + 5'h01;
    end
    always_ff @(posedge core_clk) begin
        sclk_q <= srst ? 1'b0 : sclk;
        cnt_q <= srst ? 5'h00 : cnt_d;
    end
    // ========================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence frame_start; $fell(select_n); endsequence
    sequence frame_end; $rose(select_n); endsequence
    a_start_outputs: assert property (
        frame_start |=> sample_strobe && serial_result_oe && hold_active && !serial_result_out)
        else $error("frame start outputs wrong");
    a_strobe_once: assert property (
        sample_strobe |=> !sample_strobe) else $error("strobe longer than one cycle");
    a_release_rise: assert property (
        frame_end |=> !serial_result_oe) else $error("output not released at rise");
    a_release_16: assert property (
        !select_n && sclk_q && !sclk && cnt_q == 5'h0F |=> !serial_result_oe)
        else $error("output not released after sixteen falls");
    // Wake frames are left out: there an early rise goes back to shutdown
    a_glitch_keeps: assert property (
        (frame_end and (cnt_q < 5'h02 && !result_unusable)) |=> $stable(shutdown_mode))
        else $error("mode changed");
    a_mid_shutdown: assert property (
        (frame_end and (cnt_q inside {[5'h02:5'h09]})) |=> shutdown_mode)
        else $error("no shutdown");
    a_late_normal: assert property (
        (frame_end and (cnt_q >= 5'h0A)) |=> !shutdown_mode) else $error("not normal");
    a_shut_holds: assert property (
        shutdown_mode && select_n |=> shutdown_mode) else $error("left shutdown");
    a_wake_flag: assert property (
        (frame_start and shutdown_mode) |=> result_unusable) else $error("wake not flagged");
    a_wake_return: assert property (
        (frame_end and (result_unusable && cnt_q < 5'h0A)) |=> shutdown_mode)
        else $error("wake frame did not return to shutdown");
endmodule
`default_nettype wire

// ===== tb/asfm_host.sv
// Purpose: Host model driving frame select and serial clock
// Assumes: Each serial clock level lasts two core_clk cycles
// Notes:   Clock stands low between frames
`timescale 1ns/1ns
`default_nettype none
module asfm_host (
    input  wire logic        core_clk,
    input  wire logic        din,
    output var  logic        sclk,
    output var  logic        select_n,
    output var  logic [15:0] word_q
);
    initial begin
        sclk = 1'b0;
        select_n = 1'b1;
        word_q = 16'h0000;
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Short frames are allowed on purpose to steer the mode
    task automatic frame(input int falls);
        select_n = 1'b0;
        for (int k = 0; k < falls; k++) begin
            step(2);
            sclk = 1'b1;
            step(2);
            word_q = {word_q[14:0], din};
            sclk = 1'b0;
        end
        step(4);
        select_n = 1'b1;
        step(12); // Quiet and acquisition interval
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench of frame and mode control
// Assumes: Host model makes every frame
// Notes:   Mode steered by count of falls
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        core_clk;
    logic        srst;
    logic [11:0] sample_result;
    logic        sclk, select_n, dout, oe, hold, strobe, shut, unusable, wake;
    logic [15:0] word;
    logic        host_din;
    int          err_count = 0;
    int          strobe_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    asfm_ctrl i_dut (.core_clk(core_clk), .srst(srst), .sclk(sclk), .select_n(select_n),
        .sample_result(sample_result), .serial_result_out(dout), .serial_result_oe(oe),
        .hold_active(hold), .sample_strobe(strobe), .shutdown_mode(shut),
        .result_unusable(unusable), .wake_done(wake));
    // Released line shows the inverse of the last bit, so a late sample is caught
    assign host_din = oe ? dout : ~dout;
    asfm_host i_host (.core_clk(core_clk), .din(host_din), .sclk(sclk), .select_n(select_n),
        .word_q(word));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // Whole run needs under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (strobe === 1'b1)
            strobe_count++;
        if (cyc == 3000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic t_word();
        chk(16'({oe, shut, unusable}), 16'h0001);
        sample_result = 12'hA5C;
        i_host.frame(16);
        chk(word, 16'h0A5C);
        chk(16'({oe, hold}), 16'h0000);
        sample_result = 12'h001;
        i_host.frame(16);
        chk(word, 16'h0001);
        chk(16'(unusable), 16'h0000);
        chk(16'(strobe_count), 16'h0002);
        $display("t_word done");
    endtask
    task automatic t_modes();
        i_host.frame(1);
        chk(16'(shut), 16'h0000);
        i_host.frame(5);
        chk(16'({shut, oe}), 16'h0002);
        i_host.frame(1);
        chk(16'(shut), 16'h0001);
        i_host.frame(9);
        chk(16'(shut), 16'h0001);
        i_host.frame(10);
        chk(16'({shut, unusable, wake}), 16'h0003);
        i_host.frame(12);
        chk(16'({shut, oe}), 16'h0000);
        i_host.frame(16);
        chk(16'(unusable), 16'h0000);
        chk(16'(strobe_count), 16'h0009);
        $display("t_modes done");
    endtask
    initial begin
        srst = 1'b1;
        sample_result = 12'h000;
        repeat (10) @(posedge core_clk);
        #1 srst = 1'b0;
        t_word();
        t_modes();
        test_done();
    end
endmodule
bind asfm_ctrl asfm_ctrl_sva i_sva (.core_clk(core_clk), .srst(srst), .sclk(sclk),
    .select_n(select_n), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .hold_active(hold_active),
    .sample_strobe(sample_strobe), .shutdown_mode(shutdown_mode),
    .result_unusable(result_unusable));
`default_nettype wire
